// ===== logic/dpf_pkg.sv
package dpf_pkg;
	localparam int DATA_W = 36;
	localparam int FIFO_DEPTH = 32;
	localparam int OFFSET_W = 10;
	// bit positions of the control pins inside the synchronised pin vector
	localparam int PIN_PORT_A_CLOCK = 0;
	localparam int PIN_PORT_B_CLOCK = 1;
	localparam int PIN_ENA = 2;
	localparam int PIN_ENB = 3;
	localparam int PIN_CSA = 4;
	localparam int PIN_CSB = 5;
	localparam int PIN_DIRA = 6;
	localparam int PIN_DIRB = 7;
	localparam int PIN_MBA = 8;
	localparam int PIN_MBB = 9;
	localparam int PIN_RS1 = 10;
	localparam int PIN_RS2 = 11;
	localparam int PIN_PRS = 12;
	localparam int PIN_SEN = 13;
	localparam int PIN_SD = 14;
	localparam int PIN_SPM = 15;
	localparam int PIN_BM = 16;
	localparam int PIN_SIZE = 17;
	localparam int PIN_BE = 18;
	localparam int PIN_CTRL_W = 19;
	// chip selects and the three resets idle high, so they reset high
	localparam logic [18:0] CTRL_RESET = 19'h01C30;
	// preset offsets and the offset-select codes that pick them
	localparam int PRESET_SMALL = 8;
	localparam int PRESET_MID = 16;
	localparam int PRESET_LARGE = 64;
	localparam logic [1:0] SEL_PARALLEL = 2'h0;
	localparam logic [1:0] SEL_SMALL = 2'h1;
	localparam logic [1:0] SEL_MID = 2'h2;
	// port b lane widths and index of the last lane per bus size
	localparam logic [5:0] LANE_W_WORD = 6'h12;
	localparam logic [5:0] LANE_W_BYTE = 6'h09;
	localparam logic [1:0] LAST_LANE_LONG = 2'h0;
	localparam logic [1:0] LAST_LANE_WORD = 2'h1;
	localparam logic [1:0] LAST_LANE_BYTE = 2'h3;
	typedef enum logic [2:0] {
		PROG_RESET,
		PROG_SERIAL,
		PROG_PAR_X,
		PROG_PAR_Y,
		PROG_DONE
	} dpf_prog_type;
	typedef struct packed {
		logic narrow;
		logic byte_sz;
		logic big;
	} dpf_cfg_type;
	localparam dpf_cfg_type CFG_RESET = 3'h0;
endpackage

// ===== logic/dpf_stream_if.sv
interface dpf_stream_if #(
	parameter int WIDTH = 36
) ();
	logic wr_valid;
	logic wr_ready;
	logic [WIDTH-1:0] wr_data;
	logic rd_valid;
	logic rd_ready;
	logic [WIDTH-1:0] rd_data;
	modport fifo (input wr_valid, input wr_data, input rd_ready,
		output wr_ready, output rd_valid, output rd_data);
	modport fill (output wr_valid, output wr_data, input wr_ready);
	modport drain (input rd_valid, input rd_data, output rd_ready);
endinterface

// ===== logic/dpf_fifo.sv
module dpf_fifo #(
	parameter int WIDTH = dpf_pkg::DATA_W,
	parameter int DEPTH = dpf_pkg::FIFO_DEPTH
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic clear_i,
	dpf_stream_if.fifo bus
);
	localparam int AW = $clog2(DEPTH);

	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
			$error("dpf_fifo depth must be a power of two, at least 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wptr;
	logic [AW:0] rptr;
	logic [AW:0] next_wptr;
	logic [AW:0] next_rptr;
	logic push;
	logic pop;

	// extra pointer bit tells full from empty when the low bits meet
	assign bus.wr_ready = (wptr[AW] == rptr[AW]) || (wptr[AW-1:0] != rptr[AW-1:0]);
	assign bus.rd_valid = (wptr != rptr);
	assign bus.rd_data = mem[rptr[AW-1:0]];
	assign push = bus.wr_valid && bus.wr_ready && !clear_i;
	assign pop = bus.rd_ready && bus.rd_valid && !clear_i;

	// pointer advance, clear returns both to the first location
	always_comb begin
		next_wptr = wptr;
		next_rptr = rptr;
		if (clear_i) begin
			next_wptr = '0;
			next_rptr = '0;
		end else begin
			if (push)
				next_wptr = wptr + 1'b1;
			if (pop)
				next_rptr = rptr + 1'b1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			wptr <= '0;
			rptr <= '0;
		end else begin
			wptr <= next_wptr;
			rptr <= next_rptr;
		end
	end

	// storage has no reset, it is never read while empty
	always_ff @(posedge mclk_i) begin
		if (push)
			mem[wptr[AW-1:0]] <= bus.wr_data;
	end

	chk_fifo_count_bound: assert property (@(posedge mclk_i) disable iff (rst_i)
		(AW+1)'(wptr - rptr) <= (AW+1)'(DEPTH))
		else $error("fifo holds more words than its depth");
endmodule // dpf_fifo

// ===== logic/dpf_port_ctrl.sv
// What this block does
// - port A edge transfers only with port A qualify high
// - port B edge transfers only with port B qualify high
// - write flag updates on port A edges, full or space-left per timing mode
// - during full reset, offset selects and serial select pick offset method
// - serial mode: each port A edge with enable low shifts one bit in
// - serial order: almost-full MSB first, almost-empty LSB last
// - port A mailbox select routes port A access to a mailbox
// - port B mailbox select shows mailbox one, else FIFO data
// - mailbox one write drops its flag; writes ignored while flag low
// - mailbox one flag rises on port B mailbox read or reset
// - mailbox two write from port B drops its flag; writes blocked while low
// - mailbox two flag rises on port A mailbox read or reset
// - both full resets low: clear pointers and zero port B output
// - rising first full reset latches method, preset, bus size, byte order
// - partial reset clears pointers and output, keeps configuration
// - narrowed bus: size high gives 9 bits, low gives 18 bits
// - serial select low picks serial load, high picks parallel or preset
// - port A direction high writes, low reads; outputs float while high
// - port B direction low writes, high reads; outputs float while low
// - chip select low needed for transfers; outputs float while high
// - narrowing low gives full 36 bits, high enables narrow sizes
// - byte order in reset: high big-endian; later selects timing mode
module dpf_port_ctrl #(
	parameter int DATA_W = dpf_pkg::DATA_W,
	parameter int DEPTH = dpf_pkg::FIFO_DEPTH,
	parameter int OFFSET_W = dpf_pkg::OFFSET_W
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic port_a_clock_i,
	input wire logic port_b_clock_i,
	input wire logic port_a_qualify_i,
	input wire logic port_b_qualify_i,
	input wire logic port_a_chip_select_n_i,
	input wire logic port_b_chip_select_n_i,
	input wire logic port_a_direction_i,
	input wire logic port_b_direction_i,
	input wire logic port_a_mailbox_select_i,
	input wire logic port_b_mailbox_select_i,
	input wire logic full_reset_first_n_i,
	input wire logic full_reset_second_n_i,
	input wire logic partial_clear_n_i,
	input wire logic offset_select_hi_serial_enable_i,
	input wire logic offset_select_lo_serial_bit_i,
	input wire logic serial_offset_program_select_i,
	input wire logic bus_narrowing_select_i,
	input wire logic bus_size_select_i,
	input wire logic byte_order_select_i,
	input wire logic [DATA_W-1:0] port_a_data_i,
	input wire logic [DATA_W-1:0] port_b_data_i,
	output logic [DATA_W-1:0] port_a_data_o,
	output logic port_a_data_oe_n_o,
	output logic [DATA_W-1:0] port_b_data_o,
	output logic port_b_data_oe_n_o,
	output logic full_or_write_space_flag_o,
	output logic mailbox_one_pending_n_o,
	output logic mailbox_two_pending_n_o,
	output logic [OFFSET_W-1:0] almost_full_offset_o,
	output logic [OFFSET_W-1:0] almost_empty_offset_o,
	output logic fall_through_timing_o
);
	localparam int CW = dpf_pkg::PIN_CTRL_W;
	localparam int PIN_W = CW + 2 * DATA_W;
	localparam int CNT_W = $clog2(2 * OFFSET_W + 1);
	localparam logic [PIN_W-1:0] PIN_RESET = PIN_W'(dpf_pkg::CTRL_RESET);

	generate
		if (DATA_W != 36 || OFFSET_W < 7) begin : g_bad_cfg
			$error("dpf_port_ctrl needs 36 data bits and offsets of 7 bits or more");
		end
	endgenerate

	logic [PIN_W-1:0] pin_raw;
	logic [PIN_W-1:0] pin_s;
	assign pin_raw = {port_b_data_i, port_a_data_i, byte_order_select_i, bus_size_select_i,
		bus_narrowing_select_i, serial_offset_program_select_i, offset_select_lo_serial_bit_i,
		offset_select_hi_serial_enable_i, partial_clear_n_i, full_reset_second_n_i,
		full_reset_first_n_i, port_b_mailbox_select_i, port_a_mailbox_select_i,
		port_b_direction_i, port_a_direction_i, port_b_chip_select_n_i,
		port_a_chip_select_n_i, port_b_qualify_i, port_a_qualify_i, port_b_clock_i,
		port_a_clock_i};

	// two-flop synchroniser per pin; data shares the clocks' latency so stays aligned
	for (genvar i = 0; i < PIN_W; i++) begin : g_sync
		logic meta;
		logic sync;
		always_ff @(posedge mclk_i) begin
			if (rst_i) begin
				meta <= PIN_RESET[i];
				sync <= PIN_RESET[i];
			end else begin
				meta <= pin_raw[i];
				sync <= meta;
			end
		end
		assign pin_s[i] = sync;
	end

	logic clk_a_s, clk_b_s, ena_s, enb_s, csa_s, csb_s, dira_s, dirb_s;
	logic mba_s, mbb_s, rs1_s, rs2_s, prs_s, sen_s, sd_s, spm_s, bm_s, size_s, be_s;
	logic [DATA_W-1:0] a_data;
	logic [DATA_W-1:0] b_data;
	assign clk_a_s = pin_s[dpf_pkg::PIN_PORT_A_CLOCK];
	assign clk_b_s = pin_s[dpf_pkg::PIN_PORT_B_CLOCK];
	assign ena_s = pin_s[dpf_pkg::PIN_ENA];
	assign enb_s = pin_s[dpf_pkg::PIN_ENB];
	assign csa_s = pin_s[dpf_pkg::PIN_CSA];
	assign csb_s = pin_s[dpf_pkg::PIN_CSB];
	assign dira_s = pin_s[dpf_pkg::PIN_DIRA];
	assign dirb_s = pin_s[dpf_pkg::PIN_DIRB];
	assign mba_s = pin_s[dpf_pkg::PIN_MBA];
	assign mbb_s = pin_s[dpf_pkg::PIN_MBB];
	assign rs1_s = pin_s[dpf_pkg::PIN_RS1];
	assign rs2_s = pin_s[dpf_pkg::PIN_RS2];
	assign prs_s = pin_s[dpf_pkg::PIN_PRS];
	assign sen_s = pin_s[dpf_pkg::PIN_SEN];
	assign sd_s = pin_s[dpf_pkg::PIN_SD];
	assign spm_s = pin_s[dpf_pkg::PIN_SPM];
	assign bm_s = pin_s[dpf_pkg::PIN_BM];
	assign size_s = pin_s[dpf_pkg::PIN_SIZE];
	assign be_s = pin_s[dpf_pkg::PIN_BE];
	assign a_data = pin_s[CW +: DATA_W];
	assign b_data = pin_s[CW + DATA_W +: DATA_W];

	logic clk_a_d, clk_b_d, rs1_d;
	logic a_rise, b_rise, rs1_rise, a_sel, b_sel, a_write, a_read, b_write, b_read;
	logic ptr_clear;
	// edge strobes and qualified accesses per port
	assign a_rise = clk_a_s && !clk_a_d;
	assign b_rise = clk_b_s && !clk_b_d;
	assign rs1_rise = rs1_s && !rs1_d;
	assign a_sel = a_rise && ena_s && !csa_s;
	assign b_sel = b_rise && enb_s && !csb_s;
	assign a_write = a_sel && dira_s;
	assign a_read = a_sel && !dira_s;
	assign b_write = b_sel && !dirb_s;
	assign b_read = b_sel && dirb_s;
	// both full resets low, or partial reset low, empty the FIFO
	assign ptr_clear = (!rs1_s && !rs2_s) || !prs_s;

	dpf_pkg::dpf_cfg_type cfg, next_cfg;
	dpf_pkg::dpf_prog_type prog, next_prog;
	logic [OFFSET_W-1:0] af_off, ae_off, next_af, next_ae;
	logic [CNT_W-1:0] bit_cnt, next_bits;

	// configuration latch and offset programming
	always_comb begin
		next_cfg = cfg;
		next_prog = prog;
		next_af = af_off;
		next_ae = ae_off;
		next_bits = bit_cnt;
		if (!rs1_s) begin
			next_prog = dpf_pkg::PROG_RESET;
		end else if (rs1_rise) begin
			next_cfg = '{narrow: bm_s, byte_sz: size_s, big: be_s};
			next_bits = '0;
			if (!spm_s) begin
				next_prog = dpf_pkg::PROG_SERIAL;
			end else begin
				next_prog = dpf_pkg::PROG_DONE;
				case ({sen_s, sd_s})
					dpf_pkg::SEL_PARALLEL: next_prog = dpf_pkg::PROG_PAR_X;
					dpf_pkg::SEL_SMALL: begin
						next_af = OFFSET_W'(dpf_pkg::PRESET_SMALL);
						next_ae = OFFSET_W'(dpf_pkg::PRESET_SMALL);
					end
					dpf_pkg::SEL_MID: begin
						next_af = OFFSET_W'(dpf_pkg::PRESET_MID);
						next_ae = OFFSET_W'(dpf_pkg::PRESET_MID);
					end
					default: begin
						next_af = OFFSET_W'(dpf_pkg::PRESET_LARGE);
						next_ae = OFFSET_W'(dpf_pkg::PRESET_LARGE);
					end
				endcase
			end
		end else if (prs_s) begin
			case (prog)
				dpf_pkg::PROG_SERIAL: begin
					// shifting through both registers puts the first bit at the top
					if (a_rise && !sen_s) begin
						{next_af, next_ae} = {af_off[OFFSET_W-2:0], ae_off, sd_s};
						next_bits = CNT_W'(bit_cnt + 1'b1);
						if (bit_cnt == CNT_W'(2 * OFFSET_W - 1))
							next_prog = dpf_pkg::PROG_DONE;
					end
				end
				dpf_pkg::PROG_PAR_X: begin
					if (a_write && !mba_s) begin
						next_ae = a_data[OFFSET_W-1:0];
						next_prog = dpf_pkg::PROG_PAR_Y;
					end
				end
				dpf_pkg::PROG_PAR_Y: begin
					if (a_write && !mba_s) begin
						next_af = a_data[OFFSET_W-1:0];
						next_prog = dpf_pkg::PROG_DONE;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			cfg <= dpf_pkg::CFG_RESET;
			prog <= dpf_pkg::PROG_RESET;
			af_off <= '0;
			ae_off <= '0;
			bit_cnt <= '0;
		end else begin
			cfg <= next_cfg;
			prog <= next_prog;
			af_off <= next_af;
			ae_off <= next_ae;
			bit_cnt <= next_bits;
		end
	end
	assign almost_full_offset_o = af_off;
	assign almost_empty_offset_o = ae_off;

	logic [DATA_W-1:0] lane_mask;
	logic [5:0] lane_w;
	logic [1:0] last_lane;
	logic [1:0] sub, next_sub;
	logic [1:0] lane_idx;
	logic [5:0] shamt;
	// lane layout of port b: long word, word or byte
	always_comb begin
		lane_w = dpf_pkg::LANE_W_WORD;
		last_lane = dpf_pkg::LAST_LANE_LONG;
		lane_mask = '1;
		if (cfg.narrow) begin
			lane_w = cfg.byte_sz ? dpf_pkg::LANE_W_BYTE : dpf_pkg::LANE_W_WORD;
			last_lane = cfg.byte_sz ? dpf_pkg::LAST_LANE_BYTE : dpf_pkg::LAST_LANE_WORD;
			lane_mask = ~({DATA_W{1'b1}} << lane_w);
		end
		lane_idx = cfg.big ? 2'(last_lane - sub) : sub;
		shamt = cfg.narrow ? 6'(lane_idx * lane_w) : 6'h00;
	end

	dpf_stream_if #(.WIDTH(DATA_W)) fifo_bus ();
	logic pop;
	// FIFO writes wait for offset programming; back-pressure shows on the flag
	assign fifo_bus.wr_valid = a_write && !mba_s && (prog == dpf_pkg::PROG_DONE)
		&& !ptr_clear;
	assign fifo_bus.wr_data = a_data;
	assign pop = b_read && !mbb_s && fifo_bus.rd_valid && (sub == last_lane) && !ptr_clear;
	assign fifo_bus.rd_ready = pop;

	dpf_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_fifo (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.clear_i(ptr_clear),
		.bus(fifo_bus.fifo)
	);

	logic [DATA_W-1:0] mb1, mb2, next_mb1, next_mb2;
	logic mb1_free, mb2_free, next_mb1_free, next_mb2_free;
	logic mb1_wr, mb2_wr;
	assign mb1_wr = a_write && mba_s && mb1_free;
	assign mb2_wr = b_write && mbb_s && mb2_free;

	// mailboxes; a write only lands while the box is free, and wins over a read in the same cycle
	always_comb begin
		next_mb1 = mb1;
		next_mb2 = mb2;
		next_mb1_free = mb1_free;
		next_mb2_free = mb2_free;
		if (!rs1_s || !prs_s)
			next_mb1_free = 1'b1;
		else if (mb1_wr) begin
			next_mb1 = a_data & lane_mask;
			next_mb1_free = 1'b0;
		end else if (b_read && mbb_s)
			next_mb1_free = 1'b1;
		if (!rs2_s || !prs_s)
			next_mb2_free = 1'b1;
		else if (mb2_wr) begin
			next_mb2 = b_data & lane_mask;
			next_mb2_free = 1'b0;
		end else if (a_read && mba_s)
			next_mb2_free = 1'b1;
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			mb1 <= '0;
			mb2 <= '0;
			mb1_free <= 1'b1;
			mb2_free <= 1'b1;
		end else begin
			mb1 <= next_mb1;
			mb2 <= next_mb2;
			mb1_free <= next_mb1_free;
			mb2_free <= next_mb2_free;
		end
	end
	assign mailbox_one_pending_n_o = mb1_free;
	assign mailbox_two_pending_n_o = mb2_free;

	logic [DATA_W-1:0] b_out, next_b_out, a_out, next_a_out;
	logic flag, next_flag, a_oe_n, next_a_oe_n, b_oe_n, next_b_oe_n, ft, next_ft;
	// port outputs, enables and the write-side flag
	always_comb begin
		next_b_out = b_out;
		next_sub = sub;
		next_a_out = a_out;
		next_flag = flag;
		next_ft = ft;
		next_a_oe_n = !(!csa_s && !dira_s);
		next_b_oe_n = !(!csb_s && dirb_s);
		if (ptr_clear) begin
			next_b_out = '0;
			next_sub = '0;
		end else if (b_read && mbb_s) begin
			next_b_out = mb1 & lane_mask;
		end else if (b_read && fifo_bus.rd_valid) begin
			next_b_out = (fifo_bus.rd_data >> shamt) & lane_mask;
			next_sub = (sub == last_lane) ? 2'h0 : 2'(sub + 1'b1);
		end
		if (a_read && mba_s)
			next_a_out = mb2;
		// both modes report room to write; full and no-room coincide here
		if (a_rise)
			next_flag = fifo_bus.wr_ready && (prog == dpf_pkg::PROG_DONE) && !ptr_clear;
		if (rs1_s)
			next_ft = !be_s;
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			b_out <= '0;
			sub <= '0;
			a_out <= '0;
			flag <= 1'b0;
			ft <= 1'b0;
			a_oe_n <= 1'b1;
			b_oe_n <= 1'b1;
			clk_a_d <= 1'b0;
			clk_b_d <= 1'b0;
			rs1_d <= 1'b1;
		end else begin
			b_out <= next_b_out;
			sub <= next_sub;
			a_out <= next_a_out;
			flag <= next_flag;
			ft <= next_ft;
			a_oe_n <= next_a_oe_n;
			b_oe_n <= next_b_oe_n;
			clk_a_d <= clk_a_s;
			clk_b_d <= clk_b_s;
			rs1_d <= rs1_s;
		end
	end
	assign port_b_data_o = b_out;
	assign port_a_data_o = a_out;
	assign full_or_write_space_flag_o = flag;
	assign fall_through_timing_o = ft;
	assign port_a_data_oe_n_o = a_oe_n;
	assign port_b_data_oe_n_o = b_oe_n;

	chk_a_unqualified: assert property (@(posedge mclk_i) disable iff (rst_i)
		(!ena_s || csa_s) |-> !fifo_bus.wr_valid && !mb1_wr)
		else $error("port A moved data without qualify and select");
	chk_b_hold_idle: assert property (@(posedge mclk_i) disable iff (rst_i)
		(!b_rise || !enb_s || csb_s) && !ptr_clear |=> $stable(port_b_data_o))
		else $error("port B output changed without a qualified edge");
	chk_flag_full: assert property (@(posedge mclk_i) disable iff (rst_i)
		a_rise && !fifo_bus.wr_ready |=> !full_or_write_space_flag_o)
		else $error("write flag high while FIFO full");
	chk_serial_bit_in: assert property (@(posedge mclk_i) disable iff (rst_i)
		prog == dpf_pkg::PROG_SERIAL && rs1_s && !rs1_rise && a_rise && !sen_s
		|=> ae_off[0] == $past(sd_s) && af_off[0] == $past(ae_off[OFFSET_W-1]))
		else $error("serial bit not shifted in");
	chk_mb1_write: assert property (@(posedge mclk_i) disable iff (rst_i)
		mb1_wr && rs1_s && prs_s |=> !mailbox_one_pending_n_o ##1 $stable(mb1))
		else $error("mailbox one write not flagged or not held");
	chk_mb1_release: assert property (@(posedge mclk_i) disable iff (rst_i)
		(b_read && mbb_s && !mb1_wr) || !prs_s |=> mailbox_one_pending_n_o)
		else $error("mailbox one flag not released");
	chk_mb2_write: assert property (@(posedge mclk_i) disable iff (rst_i)
		!mailbox_two_pending_n_o |-> !mb2_wr ##1 $stable(mb2))
		else $error("mailbox two overwritten while pending");
	chk_mb2_release: assert property (@(posedge mclk_i) disable iff (rst_i)
		(a_read && mba_s && !mb2_wr) || !rs2_s |=> mailbox_two_pending_n_o)
		else $error("mailbox two flag not released");
	chk_clear_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
		ptr_clear |=> port_b_data_o == '0 && !fifo_bus.rd_valid)
		else $error("clear left data behind");
	chk_partial_keeps: assert property (@(posedge mclk_i) disable iff (rst_i)
		!prs_s && rs1_s |=> $stable(af_off) && $stable(ae_off) && $stable(cfg))
		else $error("partial reset disturbed configuration");
	chk_cfg_latch: assert property (@(posedge mclk_i) disable iff (rst_i)
		rs1_rise |=> cfg.narrow == $past(bm_s) && cfg.big == $past(be_s))
		else $error("bus configuration not latched");
	chk_b_float: assert property (@(posedge mclk_i) disable iff (rst_i)
		(!dirb_s || csb_s) |=> port_b_data_oe_n_o)
		else $error("port B driven while writing or deselected");
endmodule // dpf_port_ctrl

// ===== bench/dpf_port_agent.sv
module dpf_port_agent (
	input wire logic mclk_i,
	output logic clk_o,
	output logic qual_o,
	output logic cs_n_o,
	output logic dir_o,
	output logic mb_o,
	output logic [35:0] data_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle pins: deselected, clock low
	initial begin
		clk_o = 1'h0;
		qual_o = 1'h0;
		cs_n_o = 1'h1;
		dir_o = 1'h0;
		mb_o = 1'h0;
		data_o = 36'h0;
	end
	// one port clock period, 4 mclk high and at least 5 low so the pin sampler sees it
	task automatic cycle(input logic q, input logic cs_n, input logic d, input logic mb,
		input logic [35:0] v);
		@(posedge mclk_i);
		qual_o <= q;
		cs_n_o <= cs_n;
		dir_o <= d;
		mb_o <= mb;
		data_o <= v;
		repeat (4) @(posedge mclk_i);
		clk_o <= 1'h1;
		repeat (4) @(posedge mclk_i);
		clk_o <= 1'h0;
		data_o <= ~v; // a released bus must not keep the old word
	endtask
endmodule // dpf_port_agent

// ===== bench/dual_port_fifo_port_control_tb.sv
module dual_port_fifo_port_control_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [9:0] OFS_Y = 10'h2A5;
	localparam logic [9:0] OFS_X = 10'h15B;
	logic mclk_i = 1'h0;
	logic rst_i = 1'h1;
	logic rs1_n = 1'h1, rs2_n = 1'h1, prs_n = 1'h1, sen = 1'h1, sd = 1'h0;
	logic serial_offset_program_select = 1'h0, bm = 1'h1, sz = 1'h0, be = 1'h0;
	logic a_clk, a_q, a_cs, a_dir, a_mb, b_clk, b_q, b_cs, b_dir, b_mb;
	logic [35:0] a_di, b_di, a_do, b_do;
	logic a_oe, b_oe, flag, pend1, pend2, ft;
	logic [9:0] af_ofs, ae_ofs;
	int err_total = 0;
	int n_checks = 0;
	// 50 MHz system clock
	always #10 mclk_i = ~mclk_i;
	dpf_port_agent ag_a (.mclk_i(mclk_i), .clk_o(a_clk), .qual_o(a_q), .cs_n_o(a_cs),
		.dir_o(a_dir), .mb_o(a_mb), .data_o(a_di));
	dpf_port_agent ag_b (.mclk_i(mclk_i), .clk_o(b_clk), .qual_o(b_q), .cs_n_o(b_cs),
		.dir_o(b_dir), .mb_o(b_mb), .data_o(b_di));
	dpf_port_ctrl dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .port_a_clock_i(a_clk),
		.port_b_clock_i(b_clk), .port_a_qualify_i(a_q), .port_b_qualify_i(b_q),
		.port_a_chip_select_n_i(a_cs), .port_b_chip_select_n_i(b_cs),
		.port_a_direction_i(a_dir), .port_b_direction_i(b_dir),
		.port_a_mailbox_select_i(a_mb), .port_b_mailbox_select_i(b_mb),
		.full_reset_first_n_i(rs1_n), .full_reset_second_n_i(rs2_n),
		.partial_clear_n_i(prs_n), .offset_select_hi_serial_enable_i(sen),
		.offset_select_lo_serial_bit_i(sd), .serial_offset_program_select_i(serial_offset_program_select),
		.bus_narrowing_select_i(bm), .bus_size_select_i(sz), .byte_order_select_i(be),
		.port_a_data_i(a_di), .port_b_data_i(b_di), .port_a_data_o(a_do),
		.port_a_data_oe_n_o(a_oe), .port_b_data_o(b_do), .port_b_data_oe_n_o(b_oe),
		.full_or_write_space_flag_o(flag), .mailbox_one_pending_n_o(pend1),
		.mailbox_two_pending_n_o(pend2), .almost_full_offset_o(af_ofs),
		.almost_empty_offset_o(ae_ofs), .fall_through_timing_o(ft));
	task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// port b read of one lane, narrow 18-bit bus
	task automatic rd_b(input logic [17:0] exp);
		ag_b.cycle(1'h1, 1'h0, 1'h1, 1'h0, 36'h0);
		chk("b lane", b_do, {18'h0, exp});
	endtask
	// full reset with serial offset load, little-endian 18-bit bus
	task automatic t_init();
		logic [19:0] bits;
		bits = {OFS_Y, OFS_X};
		repeat (20) @(posedge mclk_i);
		rst_i <= 1'h0;
		rs1_n <= 1'h0;
		rs2_n <= 1'h0;
		repeat (5) ag_a.cycle(1'h0, 1'h1, 1'h0, 1'h0, 36'h0);
		repeat (5) ag_b.cycle(1'h0, 1'h1, 1'h1, 1'h0, 36'h0);
		chk("b out reset", b_do, 36'h0);
		rs1_n <= 1'h1;
		rs2_n <= 1'h1;
		repeat (4) @(posedge mclk_i);
		be <= 1'h1;
		sen <= 1'h0;
		for (int i = 19; i >= 0; i--) begin
			sd <= bits[i];
			ag_a.cycle(1'h0, 1'h1, 1'h0, 1'h0, 36'h0);
		end
		sen <= 1'h1;
		repeat (4) @(posedge mclk_i);
		chk("af ofs", {26'h0, af_ofs}, {26'h0, OFS_Y});
		chk("ae ofs", {26'h0, ae_ofs}, {26'h0, OFS_X});
		chk("fall through", {35'h0, ft}, 36'h0);
		$display("t_init done");
	endtask
	// unqualified and deselected edges do nothing; lanes low first
	task automatic t_fifo();
		ag_a.cycle(1'h0, 1'h0, 1'h1, 1'h0, 36'h111111111);
		ag_a.cycle(1'h1, 1'h1, 1'h1, 1'h0, 36'h222222222);
		chk("a oe write", {35'h0, a_oe}, 36'h1);
		ag_a.cycle(1'h1, 1'h0, 1'h1, 1'h0, 36'h9ABC12345);
		rd_b(18'h12345);
		chk("b oe read", {35'h0, b_oe}, 36'h0);
		ag_b.cycle(1'h0, 1'h0, 1'h1, 1'h0, 36'h0);
		chk("b unqual", b_do, 36'h12345);
		rd_b(18'h26AF0);
		rd_b(18'h26AF0);
		$display("t_fifo done");
	endtask
	// both mailboxes, blocked second write, low lane masking
	task automatic t_mail();
		ag_a.cycle(1'h1, 1'h0, 1'h1, 1'h1, 36'hABCDE1111);
		chk("mb1 set", {35'h0, pend1}, 36'h0);
		ag_a.cycle(1'h1, 1'h0, 1'h1, 1'h1, 36'h555555555);
		ag_b.cycle(1'h1, 1'h0, 1'h1, 1'h1, 36'h0);
		chk("mb1 data", b_do, 36'h21111);
		chk("mb1 free", {35'h0, pend1}, 36'h1);
		ag_b.cycle(1'h1, 1'h0, 1'h0, 1'h1, 36'h87654FEDC);
		chk("mb2 set", {35'h0, pend2}, 36'h0);
		chk("b oe write", {35'h0, b_oe}, 36'h1);
		ag_b.cycle(1'h1, 1'h0, 1'h0, 1'h1, 36'h333333333);
		ag_a.cycle(1'h1, 1'h0, 1'h0, 1'h1, 36'h0);
		chk("mb2 data", a_do, 36'h0FEDC);
		chk("mb2 free", {35'h0, pend2}, 36'h1);
		chk("a oe read", {35'h0, a_oe}, 36'h0);
		$display("t_mail done");
	endtask
	// fill 32 words until refused, drain until empty
	task automatic t_full();
		for (int i = 0; i < 32; i++) begin
			ag_a.cycle(1'h1, 1'h0, 1'h1, 1'h0, {18'(i), 18'h3FFFF - 18'(i)});
		end
		ag_a.cycle(1'h0, 1'h1, 1'h1, 1'h0, 36'h0);
		chk("flag full", {35'h0, flag}, 36'h0);
		ag_a.cycle(1'h1, 1'h0, 1'h1, 1'h0, 36'h0000F0000);
		for (int i = 0; i < 32; i++) begin
			rd_b(18'h3FFFF - 18'(i));
			rd_b(18'(i));
		end
		rd_b(18'h1F);
		ag_a.cycle(1'h0, 1'h1, 1'h1, 1'h0, 36'h0);
		chk("flag room", {35'h0, flag}, 36'h1);
		$display("t_full done");
	endtask
	// partial clear empties data and mail, keeps offsets
	task automatic t_clear();
		ag_a.cycle(1'h1, 1'h0, 1'h1, 1'h0, 36'h0000ABCDE);
		ag_a.cycle(1'h1, 1'h0, 1'h1, 1'h1, 36'h000000777);
		rd_b(18'h2BCDE);
		prs_n <= 1'h0;
		repeat (8) @(posedge mclk_i);
		prs_n <= 1'h1;
		repeat (4) @(posedge mclk_i);
		chk("b out clear", b_do, 36'h0);
		chk("mb1 clear", {35'h0, pend1}, 36'h1);
		chk("af kept", {26'h0, af_ofs}, {26'h0, OFS_Y});
		rd_b(18'h0);
		$display("t_clear done");
	endtask
	// mid-run full reset; configuration pins are set while both resets are low
	task automatic rst_full(input logic s, input logic hi, input logic lo, input logic n,
		input logic z, input logic e);
		rs1_n <= 1'h0;
		rs2_n <= 1'h0;
		serial_offset_program_select <= s;
		sen <= hi;
		sd <= lo;
		bm <= n;
		sz <= z;
		be <= e;
		repeat (4) begin
			ag_a.cycle(1'h0, 1'h1, 1'h0, 1'h0, 36'h0);
			ag_b.cycle(1'h0, 1'h1, 1'h1, 1'h0, 36'h0);
		end
		chk("b out full reset", b_do, 36'h0);
		rs1_n <= 1'h1;
		rs2_n <= 1'h1;
		repeat (4) @(posedge mclk_i);
	endtask
	// parallel offsets, big-endian byte bus, then fall-through timing
	task automatic t_par();
		rst_full(1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1);
		sen <= 1'h1;
		ag_a.cycle(1'h1, 1'h0, 1'h1, 1'h0, {26'h0, OFS_X});
		chk("flag unprogrammed", {35'h0, flag}, 36'h0);
		ag_a.cycle(1'h1, 1'h0, 1'h1, 1'h0, {26'h0, OFS_Y});
		chk("ae par", {26'h0, ae_ofs}, {26'h0, OFS_X});
		chk("af par", {26'h0, af_ofs}, {26'h0, OFS_Y});
		ag_a.cycle(1'h1, 1'h0, 1'h1, 1'h0, 36'h123456789);
		chk("flag programmed", {35'h0, flag}, 36'h1);
		ag_b.cycle(1'h1, 1'h0, 1'h1, 1'h0, 36'h0);
		chk("b byte 3", b_do, 36'h024);
		ag_b.cycle(1'h1, 1'h0, 1'h1, 1'h0, 36'h0);
		chk("b byte 2", b_do, 36'h0D1);
		ag_b.cycle(1'h1, 1'h0, 1'h1, 1'h0, 36'h0);
		chk("b byte 1", b_do, 36'h0B3);
		ag_b.cycle(1'h1, 1'h0, 1'h1, 1'h0, 36'h0);
		chk("b byte 0", b_do, 36'h189);
		ag_a.cycle(1'h1, 1'h0, 1'h1, 1'h1, 36'hFFFFFFFFF);
		ag_b.cycle(1'h1, 1'h0, 1'h1, 1'h1, 36'h0);
		chk("mb1 byte", b_do, 36'h1FF);
		be <= 1'h0;
		repeat (4) @(posedge mclk_i);
		chk("fall through on", {35'h0, ft}, 36'h1);
		$display("t_par done");
	endtask
	// preset offset 16 and the full 36-bit bus
	task automatic t_preset();
		rst_full(1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1);
		chk("af preset", {26'h0, af_ofs}, 36'(dpf_pkg::PRESET_MID));
		chk("ae preset", {26'h0, ae_ofs}, 36'(dpf_pkg::PRESET_MID));
		ag_a.cycle(1'h1, 1'h0, 1'h1, 1'h0, 36'h9ABC12345);
		ag_b.cycle(1'h1, 1'h0, 1'h1, 1'h0, 36'h0);
		chk("b long word", b_do, 36'h9ABC12345);
		chk("fall through off", {35'h0, ft}, 36'h0);
		$display("t_preset done");
	endtask
	initial begin
		t_init();
		t_fifo();
		t_mail();
		t_full();
		t_clear();
		t_par();
		t_preset();
		test_done();
	end
endmodule // dual_port_fifo_port_control_tb
